// File: sss_pkg.sv
// Operation
// - Test output selector: 0-3 shutters, 4-5 substrate mux, 6 invalid, 7 pair.
// - Substrate-0 mux: clear gives pulse 0, set gives shutter 0 caret pulse 0.
// - Substrate-1 mux: clear gives pulse 1, set gives shutter 0 caret pulse 1.
// - Pair mux: clear combines shutters 0 and 1, set combines 0 and 2.
// - Substrate mode 0 on at exposure start, mode 1 at readout; off readout end.
// - Mode 0 substrate output turns on at the programmed on line.
// - Substrate on line is twelve bits, any line 0 to 4095.
// - Keep-on bit holds substrate pulse active after readout ends.
// - Start polarity bit sets substrate output level while on.
// - Manual enable makes shutter follow manual level bit; zero disables manual.
// - Shutter on point uses 12-bit field, 12-bit line, 13-bit pixel.
// - Shutter off point has its own field, line and pixel values.
// - Readout count sets fields of substrate clock suppression during readout.
// - Exposure count sets fields suppressing substrate clock and sensor gate.
// - Trigger write arms chosen signals, starts exposure; readout follows.
// - Register writes take effect at next vertical sync falling edge; exposure and readout counts at once.
// - Each vertical sync fall after exposure starts next readout field.
// - Shutter already on ignores triggered on toggle; only off acts.
// - After exposure, sensor gate returns to draft; after readout, substrate clock resumes.
// - Without keep-on, substrate output returns inactive at readout end.
package sss_pkg;

  localparam int SSS_REG_W = 26;
  localparam int SSS_NREG = 32;
  localparam logic [7:0] SSS_ADDR_FIRST = 8'h61;
  localparam logic [7:0] SSS_ADDR_LAST = 8'h80;
  localparam logic [7:0] SSS_ADDR_STATUS = 8'h60;
  localparam logic [7:0] SSS_ADDR_TRIGGER = 8'h61;
  localparam logic [7:0] SSS_ADDR_READOUT = 8'h62;
  localparam logic [7:0] SSS_ADDR_EXPOSURE = 8'h63;
  localparam logic [7:0] SSS_ADDR_SUB1_MODE = 8'h64;
  localparam logic [7:0] SSS_ADDR_SUB1_ON = 8'h65;
  localparam logic [7:0] SSS_ADDR_ROUTE = 8'h66;
  localparam logic [7:0] SSS_ADDR_SUB0_MODE = 8'h69;
  localparam logic [7:0] SSS_ADDR_SUB0_ON = 8'h6A;
  localparam logic [7:0] SSS_SHUT_CTRL_ADDR [4] = '{8'h6B, 8'h72, 8'h77, 8'h7C};
  localparam logic [7:0] SSS_SHUTTER_ON_FIELD_ADDR [4] = '{8'h6C, 8'h73, 8'h78, 8'h7D};
  localparam logic [7:0] SSS_SHUT_ON_POS_ADDR [4] = '{8'h6D, 8'h74, 8'h79, 8'h7E};
  localparam logic [7:0] SSS_SHUTTER_OFF_FIELD_ADDR [4] = '{8'h70, 8'h75, 8'h7A, 8'h7F};
  localparam logic [7:0] SSS_SHUT_OFF_POS_ADDR [4] = '{8'h71, 8'h76, 8'h7B, 8'h80};
  localparam logic [7:0] SSS_SUB_MODE_ADDR [2] = '{8'h69, 8'h64};
  localparam logic [7:0] SSS_SUB_ON_ADDR [2] = '{8'h6A, 8'h65};

  // Field positions
  localparam int SSS_POS_PIXEL_LSB = 13;
  localparam int SSS_TRIG_SUB0_BIT = 4;
  localparam int SSS_TRIG_EXPOSE_BIT = 7;
  localparam int SSS_SUB_MODE_BIT = 0;
  localparam int SSS_SUB_KEEP_BIT = 1;
  localparam int SSS_SUB_POL_BIT = 2;
  localparam int SSS_SHUT_POL_BIT = 1;
  localparam int SSS_SHUTTER_MANUAL_ENABLE_EN_BIT = 2;
  localparam int SSS_SHUTTER_MANUAL_ENABLE_LVL_BIT = 3;
  localparam int SSS_ROUTE_SEL_LSB = 0;
  localparam int SSS_ROUTE_SUB0_MUX_BIT = 3;
  localparam int SSS_ROUTE_SUB1_MUX_BIT = 4;
  localparam int SSS_ROUTE_PAIR_MUX_BIT = 5;
  localparam int SSS_STAT_FIELD_LSB = 2;
  localparam int SSS_STAT_PEND_BIT = 10;
  localparam int SSS_STAT_SHUT_LSB = 11;
  localparam int SSS_STAT_SUB_LSB = 15;

  localparam logic [SSS_REG_W-1:0] SSS_REG_RESET = 26'h0000000;

  typedef enum logic [2:0] {
    SSS_ROUTE_SHUTTER_SIG_0 = 3'h0,
    SSS_ROUTE_SHUTTER_SIG_1 = 3'h1,
    SSS_ROUTE_SHUTTER_SIG_2 = 3'h2,
    SSS_ROUTE_SHUTTER_SIG_3 = 3'h3,
    SSS_ROUTE_SUB0 = 3'h4,
    SSS_ROUTE_SUB1 = 3'h5,
    SSS_ROUTE_INVALID = 3'h6,
    SSS_ROUTE_PAIR = 3'h7
  } sss_route_type;

  typedef enum logic [1:0] {
    SSS_SEQ_IDLE = 2'b00,
    SSS_SEQ_EXPOSE = 2'b01,
    SSS_SEQ_READOUT = 2'b10
  } sss_seq_type;

endpackage : sss_pkg

// File: sss_shutter_substrate.sv
module sss_shutter_substrate
  import sss_pkg::*;
#(
  parameter int LINE_W = 12,
  parameter int PIXEL_W = 13,
  parameter int FIELD_W = 12,
  parameter int COUNT_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [SSS_REG_W-1:0] reg_wr_data,
  output logic [SSS_REG_W-1:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic vertical_sync,
  input wire logic horizontal_sync,
  output logic [3:0] shutter_sig,
  output logic [1:0] substrate_pulse,
  output logic test_output,
  output logic substrate_clock_enable,
  output logic sensor_gate_enable
);

  if (LINE_W < 1 || LINE_W > 12 || PIXEL_W < 1 || PIXEL_W > 13 ||
      FIELD_W < 1 || FIELD_W > 12 || COUNT_W < 1 || COUNT_W > 8) begin : g_bad_w
    $error("sss_shutter_substrate: unsupported width parameter");
  end

  localparam int IDX_TRIG = int'(SSS_ADDR_TRIGGER - SSS_ADDR_FIRST);
  localparam int IDX_READ = int'(SSS_ADDR_READOUT - SSS_ADDR_FIRST);
  localparam int IDX_EXPO = int'(SSS_ADDR_EXPOSURE - SSS_ADDR_FIRST);
  localparam int IDX_ROUTE = int'(SSS_ADDR_ROUTE - SSS_ADDR_FIRST);

  // ----------------------------------------------------------------
  // Sync pin capture and edge detection
  // ----------------------------------------------------------------
  logic vs_meta, vs_sync, vs_prev;
  logic hs_meta, hs_sync, hs_prev;
  logic vd_fall, hd_fall;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vs_meta <= 1'b1;
      vs_sync <= 1'b1;
      vs_prev <= 1'b1;
      hs_meta <= 1'b1;
      hs_sync <= 1'b1;
      hs_prev <= 1'b1;
    end else begin
      vs_meta <= vertical_sync;
      vs_sync <= vs_meta;
      vs_prev <= vs_sync;
      hs_meta <= horizontal_sync;
      hs_sync <= hs_meta;
      hs_prev <= hs_sync;
    end
  end

  assign vd_fall = vs_prev & ~vs_sync;
  assign hd_fall = hs_prev & ~hs_sync;

  // ----------------------------------------------------------------
  // Register file: shadow written by host, active copy used by shutter, substrate and route logic
  // ----------------------------------------------------------------
  logic [SSS_REG_W-1:0] shadow [SSS_NREG];
  logic [SSS_REG_W-1:0] active [SSS_NREG];
  logic [7:0] reg_off;
  logic reg_mapped;
  logic trig_write, trig_pend;

  assign reg_off = reg_addr - SSS_ADDR_FIRST;
  assign reg_mapped = (reg_addr >= SSS_ADDR_FIRST) &&
                      (reg_addr <= SSS_ADDR_LAST);
  assign trig_write = reg_wr_en && (reg_addr == SSS_ADDR_TRIGGER);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < SSS_NREG; k++) begin
        shadow[k] <= SSS_REG_RESET;
      end
    end else if (reg_wr_en && reg_mapped) begin
      shadow[reg_off[4:0]] <= reg_wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < SSS_NREG; k++) begin
        active[k] <= SSS_REG_RESET;
      end
    end else if (vd_fall) begin
      for (int k = 0; k < SSS_NREG; k++) begin
        active[k] <= shadow[k];
      end
    end
  end

  // A trigger write in the same cycle as the apply edge survives it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trig_pend <= 1'b0;
    end else if (trig_write) begin
      trig_pend <= 1'b1;
    end else if (vd_fall) begin
      trig_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Line and pixel position counters
  // ----------------------------------------------------------------
  logic [LINE_W-1:0] line_cnt;
  logic [PIXEL_W-1:0] pixel_cnt;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt <= '0;
    end else if (vd_fall) begin
      line_cnt <= '0;
    end else if (hd_fall && line_cnt != '1) begin
      line_cnt <= line_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pixel_cnt <= '0;
    end else if (vd_fall || hd_fall) begin
      pixel_cnt <= '0;
    end else if (pixel_cnt != '1) begin
      pixel_cnt <= pixel_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Exposure and readout sequence
  // ----------------------------------------------------------------
  sss_seq_type seq_state;
  logic [COUNT_W-1:0] field_cnt;
  logic [COUNT_W-1:0] field_inc;
  logic [COUNT_W-1:0] expose_fields, readout_fields;
  logic seq_start, expose_last, readout_last, seq_done;

  assign field_inc = field_cnt + 1'b1;
  assign expose_fields = shadow[IDX_EXPO][COUNT_W-1:0];
  assign readout_fields = shadow[IDX_READ][COUNT_W-1:0];
  assign seq_start = vd_fall && trig_pend && seq_state == SSS_SEQ_IDLE &&
                     shadow[IDX_TRIG][SSS_TRIG_EXPOSE_BIT];
  assign expose_last = field_inc >= expose_fields;
  assign readout_last = field_inc >= readout_fields;
  assign seq_done = vd_fall && seq_state == SSS_SEQ_READOUT && readout_last;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_state <= SSS_SEQ_IDLE;
      field_cnt <= '0;
    end else if (vd_fall) begin
      case (seq_state)
        SSS_SEQ_IDLE: begin
          if (seq_start) begin
            seq_state <= SSS_SEQ_EXPOSE;
            field_cnt <= '0;
          end
        end
        SSS_SEQ_EXPOSE: begin
          if (expose_last) begin
            seq_state <= SSS_SEQ_READOUT;
            field_cnt <= '0;
          end else begin
            field_cnt <= field_inc;
          end
        end
        SSS_SEQ_READOUT: begin
          if (readout_last) begin
            seq_state <= SSS_SEQ_IDLE;
            field_cnt <= '0;
          end else begin
            field_cnt <= field_inc;
          end
        end
        default: begin
          seq_state <= SSS_SEQ_IDLE;
          field_cnt <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      substrate_clock_enable <= 1'b1;
      sensor_gate_enable <= 1'b1;
    end else begin
      substrate_clock_enable <= seq_state == SSS_SEQ_IDLE;
      sensor_gate_enable <= seq_state != SSS_SEQ_EXPOSE;
    end
  end

  // ----------------------------------------------------------------
  // Shutter signals
  // ----------------------------------------------------------------
  logic [3:0] shut_on, shut_lvl;

  for (genvar i = 0; i < 4; i++) begin : g_shut
    localparam int CI = int'(SSS_SHUT_CTRL_ADDR[i] - SSS_ADDR_FIRST);
    localparam int OFI = int'(SSS_SHUTTER_ON_FIELD_ADDR[i] - SSS_ADDR_FIRST);
    localparam int OPI = int'(SSS_SHUT_ON_POS_ADDR[i] - SSS_ADDR_FIRST);
    localparam int FFI = int'(SSS_SHUTTER_OFF_FIELD_ADDR[i] - SSS_ADDR_FIRST);
    localparam int FPI = int'(SSS_SHUT_OFF_POS_ADDR[i] - SSS_ADDR_FIRST);
    logic armed, single;
    logic man_en, man_lvl, on_field, off_field, on_hit, off_hit;

    assign man_en = active[CI][SSS_SHUTTER_MANUAL_ENABLE_EN_BIT];
    assign man_lvl = active[CI][SSS_SHUTTER_MANUAL_ENABLE_LVL_BIT];
    assign on_field = single || (seq_state == SSS_SEQ_EXPOSE &&
      FIELD_W'(field_cnt) == active[OFI][FIELD_W-1:0]);
    assign off_field = single || (seq_state == SSS_SEQ_EXPOSE &&
      FIELD_W'(field_cnt) == active[FFI][FIELD_W-1:0]);
    // Manual mode ignores field and arming
    assign on_hit = line_cnt == active[OPI][LINE_W-1:0] &&
      pixel_cnt == active[OPI][SSS_POS_PIXEL_LSB +: PIXEL_W] &&
      (man_en ? man_lvl : armed && on_field);
    assign off_hit = line_cnt == active[FPI][LINE_W-1:0] &&
      pixel_cnt == active[FPI][SSS_POS_PIXEL_LSB +: PIXEL_W] &&
      (man_en ? !man_lvl : armed && off_field);

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        armed <= 1'b0;
        single <= 1'b0;
      end else if (vd_fall && trig_pend && shadow[IDX_TRIG][i]) begin
        armed <= 1'b1;
        single <= !shadow[IDX_TRIG][SSS_TRIG_EXPOSE_BIT];
      end else if ((off_hit && !man_en) || seq_done ||
                   (vd_fall && single)) begin
        armed <= 1'b0;
        single <= 1'b0;
      end
    end

    // Already-on shutter keeps state on on toggle
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        shut_on[i] <= 1'b0;
      end else if (off_hit) begin
        shut_on[i] <= 1'b0;
      end else if (on_hit) begin
        shut_on[i] <= 1'b1;
      end
    end

    assign shut_lvl[i] = active[CI][SSS_SHUT_POL_BIT] ? shut_on[i]
                                                       : !shut_on[i];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shutter_sig <= 4'h0;
    end else begin
      shutter_sig <= shut_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Substrate pulses
  // ----------------------------------------------------------------
  logic [1:0] sub_on, sub_lvl;

  for (genvar j = 0; j < 2; j++) begin : g_sub
    localparam int MI = int'(SSS_SUB_MODE_ADDR[j] - SSS_ADDR_FIRST);
    localparam int NI = int'(SSS_SUB_ON_ADDR[j] - SSS_ADDR_FIRST);
    logic armed, keep, start_phase, on_hit;

    assign keep = active[MI][SSS_SUB_KEEP_BIT];
    // Mode picks exposure or readout start
    assign start_phase = active[MI][SSS_SUB_MODE_BIT] ?
      seq_state == SSS_SEQ_READOUT : seq_state == SSS_SEQ_EXPOSE;
    assign on_hit = armed && start_phase && field_cnt == '0 &&
      line_cnt == active[NI][LINE_W-1:0] && pixel_cnt == '0;

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        armed <= 1'b0;
      end else if (seq_start) begin
        armed <= shadow[IDX_TRIG][SSS_TRIG_SUB0_BIT + j];
      end else if (on_hit || seq_done) begin
        armed <= 1'b0;
      end
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        sub_on[j] <= 1'b0;
      end else if (on_hit) begin
        sub_on[j] <= 1'b1;
      end else if (seq_done && !keep) begin
        sub_on[j] <= 1'b0;
      end else if (vd_fall && !keep && seq_state == SSS_SEQ_IDLE) begin
        sub_on[j] <= 1'b0;
      end
    end

    assign sub_lvl[j] = active[MI][SSS_SUB_POL_BIT] ? sub_on[j]
                                                     : !sub_on[j];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      substrate_pulse <= 2'h0;
    end else begin
      substrate_pulse <= sub_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Test output routing
  // ----------------------------------------------------------------
  sss_route_type route_sel;
  logic sub0_mux, sub1_mux, pair_mux, next_test;

  assign route_sel = sss_route_type'(active[IDX_ROUTE][SSS_ROUTE_SEL_LSB +: 3]);
  assign sub0_mux = active[IDX_ROUTE][SSS_ROUTE_SUB0_MUX_BIT];
  assign sub1_mux = active[IDX_ROUTE][SSS_ROUTE_SUB1_MUX_BIT];
  assign pair_mux = active[IDX_ROUTE][SSS_ROUTE_PAIR_MUX_BIT];

  // Selector; caret taken as exclusive or
  always_comb begin
    case (route_sel)
      SSS_ROUTE_SHUTTER_SIG_0: next_test = shut_lvl[0];
      SSS_ROUTE_SHUTTER_SIG_1: next_test = shut_lvl[1];
      SSS_ROUTE_SHUTTER_SIG_2: next_test = shut_lvl[2];
      SSS_ROUTE_SHUTTER_SIG_3: next_test = shut_lvl[3];
      SSS_ROUTE_SUB0: next_test = sub0_mux ? shut_lvl[0] ^ sub_lvl[0]
                                           : sub_lvl[0];
      SSS_ROUTE_SUB1: next_test = sub1_mux ? shut_lvl[0] ^ sub_lvl[1]
                                           : sub_lvl[1];
      SSS_ROUTE_PAIR: next_test = pair_mux ? shut_lvl[0] ^ shut_lvl[2]
                                           : shut_lvl[0] ^ shut_lvl[1];
      default: next_test = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      test_output <= 1'b0;
    end else begin
      test_output <= next_test;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [SSS_REG_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[1:0] = seq_state;
    status_word[SSS_STAT_FIELD_LSB +: 8] = 8'(field_cnt);
    status_word[SSS_STAT_PEND_BIT] = trig_pend;
    status_word[SSS_STAT_SHUT_LSB +: 4] = shut_on;
    status_word[SSS_STAT_SUB_LSB +: 2] = sub_on;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en && reg_addr == SSS_ADDR_STATUS) begin
        reg_rd_data <= status_word;
      end else if (reg_rd_en && reg_mapped) begin
        reg_rd_data <= shadow[reg_off[4:0]];
      end else if (reg_rd_en) begin
        reg_rd_data <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_done_edge;
    seq_state == SSS_SEQ_READOUT && vd_fall && readout_last;
  endsequence

  sequence s_released;
    seq_state == SSS_SEQ_IDLE ##1 substrate_clock_enable && sensor_gate_enable;
  endsequence

  chk_route_shutter_sig_0: assert property (
    route_sel == SSS_ROUTE_SHUTTER_SIG_0 |=> test_output == $past(shut_lvl[0]))
    else $error("test output does not follow shutter 0");

  chk_sub0_combine: assert property (
    route_sel == SSS_ROUTE_SUB0 && sub0_mux
    |=> test_output == ($past(shut_lvl[0]) ^ $past(sub_lvl[0])))
    else $error("substrate 0 combination wrong");

  chk_sub1_plain: assert property (
    route_sel == SSS_ROUTE_SUB1 && !sub1_mux
    |=> test_output == $past(sub_lvl[1]))
    else $error("substrate 1 plain route wrong");

  chk_pair_combine: assert property (
    route_sel == SSS_ROUTE_PAIR && pair_mux
    |=> test_output == ($past(shut_lvl[0]) ^ $past(shut_lvl[2])))
    else $error("shutter pair combination wrong");

  chk_expose_suppress: assert property (
    seq_state == SSS_SEQ_EXPOSE |=> !substrate_clock_enable &&
    !sensor_gate_enable)
    else $error("exposure does not suppress clocks");

  chk_write_deferred: assert property (
    !vd_fall |=> $stable(active[IDX_ROUTE]))
    else $error("register applied outside vertical fall");

  chk_readout_step: assert property (
    seq_state == SSS_SEQ_READOUT && vd_fall && !readout_last
    |=> seq_state == SSS_SEQ_READOUT && field_cnt == $past(field_inc))
    else $error("readout field did not advance");

  chk_done_release: assert property (
    s_done_edge |=> s_released)
    else $error("clocks not released after readout");

  chk_sub_keep_off: assert property (
    s_done_edge and !g_sub[0].keep and !g_sub[0].on_hit |=> !sub_on[0])
    else $error("substrate stayed on without keep-on");

  chk_sub_keep_on: assert property (
    s_done_edge and g_sub[0].keep and sub_on[0] |=> sub_on[0])
    else $error("keep-on substrate dropped");

  chk_shut_already_on: assert property (
    shut_on[1] && g_shut[1].on_hit && !g_shut[1].off_hit |=> shut_on[1])
    else $error("on toggle disturbed an already-on shutter");

endmodule : sss_shutter_substrate

// File: sss_sync_partner.sv
module sss_sync_partner #(
  parameter int LINE_CLKS = 40,
  parameter int FIELD_LINES = 8
) (
  input wire logic clock,
  output logic vertical_sync,
  output logic horizontal_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  int pix = 0;
  int ln = 0;
  // ------------------------------------------
  // Line and field syncs, two-clock low pulses
  // ------------------------------------------
  initial begin
    vertical_sync = 1'b1;
    horizontal_sync = 1'b1;
  end
  always @(negedge clock) begin
    pix = (pix + 1) % LINE_CLKS;
    if (pix == 0) ln = (ln + 1) % FIELD_LINES;
    horizontal_sync <= (pix >= 2);
    vertical_sync <= !(ln == 0 && pix < 2);
  end
endmodule : sss_sync_partner

// File: test_shutter_substrate_signal_ctrl.sv
module test_shutter_substrate_signal_ctrl
  import sss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [SSS_REG_W-1:0] reg_wr_data = '0;
  logic [SSS_REG_W-1:0] reg_rd_data;
  logic [SSS_REG_W-1:0] d;
  logic reg_rd_valid, vertical_sync, horizontal_sync, test_output;
  logic substrate_clock_enable, sensor_gate_enable;
  logic [3:0] shutter_sig;
  logic [1:0] substrate_pulse;
  logic [3:0] es;
  logic [1:0] eb;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  sss_shutter_substrate uut (.clock(clock), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .vertical_sync(vertical_sync),
    .horizontal_sync(horizontal_sync), .shutter_sig(shutter_sig),
    .substrate_pulse(substrate_pulse), .test_output(test_output),
    .substrate_clock_enable(substrate_clock_enable),
    .sensor_gate_enable(sensor_gate_enable));
  sss_sync_partner far_side (.clock(clock), .vertical_sync(vertical_sync),
    .horizontal_sync(horizontal_sync));
  initial begin
    forever #50 clock = ~clock;
  end
  // ----------------------------
  // Bus tasks and reference model
  // ----------------------------
  task automatic wr(input logic [7:0] a, input logic [SSS_REG_W-1:0] v);
    @(negedge clock);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = v;
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [SSS_REG_W-1:0] e);
    @(negedge clock);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd_en = 1'b0;
    `CHK(reg_rd_valid, 1'b1)
    `CHK(reg_rd_data, e)
    @(negedge clock);
    `CHK(reg_rd_valid, 1'b0)
  endtask : rdchk
  task automatic go(input bit f, input int l);
    if (f) @(negedge vertical_sync);
    repeat (l * 40 + 20) @(negedge clock);
  endtask : go
  function automatic logic route_model(input logic [2:0] s,
      input logic m0, input logic m1, input logic mp);
    case (s)
      3'h4: return m0 ? es[0] ^ eb[0] : eb[0];
      3'h5: return m1 ? es[0] ^ eb[1] : eb[1];
      3'h7: return mp ? es[0] ^ es[2] : es[0] ^ es[1];
      default: return es[s[1:0]];
    endcase
  endfunction : route_model
  task automatic stop_test;
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'hBACD68DF));
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK(shutter_sig, 4'hF)
    `CHK(substrate_clock_enable, 1'b1)
    rdchk(SSS_ADDR_TRIGGER, '0);
    rdchk(8'h5F, '0);
    for (int k = 0; k < 8; k++) begin
      if (k == 6) continue;
      for (int i = 0; i < 4; i++) begin
        es[i] = 1'($urandom);
        d = '0;
        d[SSS_SHUT_POL_BIT] = ~es[i];
        wr(SSS_SHUT_CTRL_ADDR[i], d);
      end
      for (int j = 0; j < 2; j++) begin
        eb[j] = 1'($urandom);
        d = '0;
        d[SSS_SUB_POL_BIT] = ~eb[j];
        wr(SSS_SUB_MODE_ADDR[j], d);
      end
      d = '0;
      d[2:0] = 3'(k);
      d[5:3] = 3'($urandom);
      wr(SSS_ADDR_ROUTE, d);
      go(1, 1);
      `CHK(shutter_sig, es)
      `CHK(substrate_pulse, eb)
      `CHK(test_output, route_model(d[2:0], d[3], d[4], d[5]))
    end
    for (int i = 0; i < 4; i++) wr(SSS_SHUT_CTRL_ADDR[i], '0);
    for (int j = 0; j < 2; j++) wr(SSS_SUB_MODE_ADDR[j], '0);
    wr(SSS_ADDR_SUB0_ON, 26'h2);
    rdchk(SSS_ADDR_SUB0_ON, 26'h2);
    wr(SSS_SHUT_ON_POS_ADDR[0], 26'h1);
    wr(SSS_SHUT_OFF_POS_ADDR[0], 26'h5);
    wr(SSS_SHUT_OFF_POS_ADDR[1], 26'h5);
    wr(SSS_SHUT_CTRL_ADDR[1], 26'hC);
    go(1, 1);
    go(1, 1);
    `CHK(shutter_sig, 4'hD)
    // field timing mode lives outside this block
    wr(SSS_SHUT_CTRL_ADDR[1], '0);
    wr(SSS_ADDR_EXPOSURE, 26'h1);
    wr(SSS_ADDR_READOUT, 26'h3);
    wr(SSS_ADDR_TRIGGER, 26'hD3);
    `CHK(substrate_clock_enable, 1'b1)
    go(1, 3);
    `CHK(shutter_sig, 4'hC)
    `CHK(substrate_pulse, 2'h2)
    `CHK({substrate_clock_enable, sensor_gate_enable}, 2'h0)
    go(0, 3);
    `CHK(shutter_sig, 4'hF)
    for (int r = 0; r < 3; r++) begin
      go(1, 4);
      `CHK(substrate_clock_enable, 1'b0)
      `CHK(substrate_pulse[0], 1'b0)
    end
    go(1, 4);
    `CHK({substrate_clock_enable, sensor_gate_enable}, 2'h3)
    `CHK(substrate_pulse, 2'h3)
    stop_test();
  end
endmodule : test_shutter_substrate_signal_ctrl
